// File: hdl/adcrf_pkg.sv
// Package: register map, field layout and shared types of the result formatting block.
// Assumes a single system clock domain and an AHB-Lite register bus.
package adcrf_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFFSET       = 8'h00;
  localparam logic [7:0] FORMAT_OFFSET     = 8'h04;
  localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h08;
  localparam logic [7:0] RESULT_LOW_OFFSET  = 8'h0c;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ENABLE_BIT  = 0;
  localparam int START_BIT   = 1;
  localparam int CHAN_LSB    = 2;
  localparam int JUSTIFY_BIT = 7;
  // ----------------------------------------------------------------
  // Widths, codes and reset values
  // ----------------------------------------------------------------
  localparam int RESULT_WIDTH = 10;
  localparam int CHAN_WIDTH   = 5;
  localparam logic [4:0] TEMP_CHANNEL     = 5'h1d;
  localparam logic [7:0] CTRL_RESET       = 8'h00;
  localparam logic [7:0] FORMAT_RESET     = 8'h00;
  localparam logic [9:0] RESULT_CODE_MAX  = 10'h3ff;

  typedef struct packed {
    logic       request;
    logic [4:0] channel;
  } adcrf_conv_req_type;

  typedef struct packed {
    logic       done;
    logic [9:0] code;
  } adcrf_conv_rsp_type;
endpackage

// File: hdl/adcrf_result_format.sv
// Digital side of the converter: control, format select and result registers.
// Assumes an analog core that answers each request with one done pulse and a code.
// Summary of operation
// [RULE_01] Left format: result bits 1..0 go to low register bits 7..6.
// [RULE_02] Right format: result bits 9..8 go to high register bits 1..0.
// [RULE_03] Right format: result bits 7..0 fill the low register.
// [RULE_04] Software waits an acquisition interval after channel change before starting.
// [RULE_05] Each result is a ten-bit unsigned code, 1024 steps.
// [RULE_06] Temperature indicator is reached internally through the channel multiplexer.
// [RULE_07] Result registers are not cleared by reset; they hold their contents.
// [RULE_08] Left format: result bits 9..2 fill the high register.
// [RULE_09] Unused six bits of the partly filled register are zero on load.
// [RULE_10] Start bit stays set during conversion and clears itself at completion.
// [RULE_11] Channel code 11101 selects the temperature indicator.
// [RULE_12] Both result registers load together, only when a conversion completes. Here bus writes to either result offset also load that register alone.
//
// Decided for this implementation: the register offsets and the AHB-Lite interface to the registers.
module adcrf_result_format (
  input  wire logic                          clk_sys,
  input  wire logic                          reset,
  input  wire logic                          hsel,
  input  wire logic [31:0]                   haddr,
  input  wire logic [1:0]                    htrans,
  input  wire logic                          hwrite,
  input  wire logic [2:0]                    hsize,
  input  wire logic [31:0]                   hwdata,
  input  wire logic                          hready,
  output logic      [31:0]                   hrdata,
  output logic                               hreadyout,
  output logic                               hresp,
  output adcrf_pkg::adcrf_conv_req_type      convReq,
  output logic                               tempSelect,
  output logic                               converterEnable,
  input  wire adcrf_pkg::adcrf_conv_rsp_type convRsp
);
  // ----------------------------------------------------------------
  // Bus address phase capture
  // ----------------------------------------------------------------
  logic       wrPending;
  logic [7:0] wrAddr;
  logic       phaseTaken;

  assign phaseTaken = hsel && hready && htrans[1];
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      wrPending <= 1'b0;
      wrAddr    <= 8'h00;
    end else begin
      wrPending <= phaseTaken && hwrite;
      wrAddr    <= phaseTaken ? haddr[7:0] : wrAddr;
    end
  end

  // ----------------------------------------------------------------
  // Control and format registers
  // ----------------------------------------------------------------
  logic       enable;
  logic       busy;
  logic [4:0] channel;
  logic       justifyRight;
  logic       wrCtrl;

  assign wrCtrl = wrPending && (wrAddr == adcrf_pkg::CTRL_OFFSET);

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      enable  <= adcrf_pkg::CTRL_RESET[adcrf_pkg::ENABLE_BIT];
      channel <= adcrf_pkg::CTRL_RESET[adcrf_pkg::CHAN_LSB +: adcrf_pkg::CHAN_WIDTH];
    end else if (wrCtrl) begin
      enable  <= hwdata[adcrf_pkg::ENABLE_BIT];
      channel <= hwdata[adcrf_pkg::CHAN_LSB +: adcrf_pkg::CHAN_WIDTH];
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      justifyRight <= adcrf_pkg::FORMAT_RESET[adcrf_pkg::JUSTIFY_BIT];
    end else if (wrPending && (wrAddr == adcrf_pkg::FORMAT_OFFSET)) begin
      justifyRight <= hwdata[adcrf_pkg::JUSTIFY_BIT];
    end
  end

  // Completion wins over a software write in the same cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy <= 1'b0;
    end else if (busy && convRsp.done) begin
      busy <= 1'b0; // RULE_10
    end else if (wrCtrl) begin
      busy <= hwdata[adcrf_pkg::START_BIT] && hwdata[adcrf_pkg::ENABLE_BIT]; // RULE_10
    end else if (!enable) begin
      busy <= 1'b0;
    end
  end

  // Start is not delayed here; software owns the acquisition wait
  assign convReq.request  = busy; // RULE_10
  assign convReq.channel  = channel;
  assign converterEnable  = enable;
  assign tempSelect       = (channel == adcrf_pkg::TEMP_CHANNEL); // RULE_06 RULE_11

  // ----------------------------------------------------------------
  // Result registers: no reset, loaded as a pair on completion
  // ----------------------------------------------------------------
  logic [7:0] resultHigh;
  logic [7:0] resultLow;
  logic [9:0] code;
  logic       loadResult;

  assign code       = convRsp.code & adcrf_pkg::RESULT_CODE_MAX; // RULE_05
  assign loadResult = busy && convRsp.done;

  always_ff @(posedge clk_sys) begin
    if (loadResult) begin // RULE_12 RULE_07
      if (justifyRight) begin
        resultHigh <= {6'h00, code[9:8]}; // RULE_02 RULE_09
        resultLow  <= code[7:0]; // RULE_03
      end else begin
        resultHigh <= code[9:2]; // RULE_08
        resultLow  <= {code[1:0], 6'h00}; // RULE_01 RULE_09
      end
    end else if (wrPending && (wrAddr == adcrf_pkg::RESULT_HIGH_OFFSET)) begin
      resultHigh <= hwdata[7:0];
    end else if (wrPending && (wrAddr == adcrf_pkg::RESULT_LOW_OFFSET)) begin
      resultLow <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [31:0] next_hrdata;

  always_comb begin
    next_hrdata = 32'h0000_0000;
    unique case (haddr[7:0])
      adcrf_pkg::CTRL_OFFSET: next_hrdata = {24'h000000, 1'b0, channel, busy, enable};
      adcrf_pkg::FORMAT_OFFSET: next_hrdata = {24'h000000, justifyRight, 7'h00};
      adcrf_pkg::RESULT_HIGH_OFFSET: next_hrdata = {24'h000000, resultHigh};
      adcrf_pkg::RESULT_LOW_OFFSET: next_hrdata = {24'h000000, resultLow};
      default: next_hrdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hrdata <= 32'h0000_0000;
    end else if (phaseTaken && !hwrite) begin
      hrdata <= next_hrdata;
    end
  end

  // ----------------------------------------------------------------
  // Assertion helper: results stay undefined until the first load
  // ----------------------------------------------------------------
  logic resultsLoaded;

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      resultsLoaded <= 1'b0;
    end else if (loadResult) begin
      resultsLoaded <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_complete;
    busy && convRsp.done;
  endsequence

  sequence s_start;
    wrCtrl && !(busy && convRsp.done) && hwdata[adcrf_pkg::START_BIT] && hwdata[adcrf_pkg::ENABLE_BIT];
  endsequence

  a_left_low_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE_01
    (s_complete and !justifyRight) |=> resultLow == {$past(code[1:0]), 6'h00})
    else $error("left low result wrong");
  a_right_high_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE_02
    (s_complete and justifyRight) |=> resultHigh[1:0] == $past(code[9:8]))
    else $error("right high result wrong");
  a_right_low_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE_03
    (s_complete and justifyRight) |=> resultLow == $past(code[7:0]))
    else $error("right low result wrong");
  a_code_range: assert property (@(posedge clk_sys) disable iff (reset) // RULE_05
    s_complete |=> ($past(justifyRight) ? {resultHigh[1:0], resultLow} : {resultHigh, resultLow[7:6]})
      == $past(convRsp.code))
    else $error("result code not rebuilt");
  a_temp_route: assert property (@(posedge clk_sys) disable iff (reset) // RULE_11
    tempSelect == (convReq.channel == 5'h1d))
    else $error("temperature route wrong");
  a_result_hold: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
    resultsLoaded && !loadResult && !wrPending |=> $stable(resultHigh) && $stable(resultLow))
    else $error("result changed without load");
  a_left_high_bits: assert property (@(posedge clk_sys) disable iff (reset) // RULE_08
    (s_complete and !justifyRight) |=> resultHigh == $past(code[9:2]))
    else $error("left high result wrong");
  a_unused_zero: assert property (@(posedge clk_sys) disable iff (reset) // RULE_09
    s_complete |=> ($past(justifyRight) ? resultHigh[7:2] == 6'h00 : resultLow[5:0] == 6'h00))
    else $error("unused bits not zero");
  a_busy_clear: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    s_complete |=> !busy ##1 1'b1)
    else $error("busy not cleared on completion");
  a_busy_set: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    s_start |=> busy)
    else $error("busy not set by start");
  a_start_ignored: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    wrCtrl && !busy && !hwdata[adcrf_pkg::ENABLE_BIT] |=> !busy)
    else $error("start accepted while disabled");
  a_busy_held: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    busy && !convRsp.done && !wrCtrl |=> busy)
    else $error("busy dropped before completion");
  a_abort_idle: assert property (@(posedge clk_sys) disable iff (reset) // RULE_10
    !enable && !wrCtrl |=> !busy)
    else $error("busy while disabled");
  a_ctrl_channel: assert property (@(posedge clk_sys) disable iff (reset) // RULE_06
    wrCtrl |=> convReq.channel == $past(hwdata[adcrf_pkg::CHAN_LSB +: adcrf_pkg::CHAN_WIDTH]))
    else $error("channel select not taken");
  a_high_write: assert property (@(posedge clk_sys) disable iff (reset) // RULE_12
    wrPending && (wrAddr == adcrf_pkg::RESULT_HIGH_OFFSET) && !loadResult |=> resultHigh == $past(hwdata[7:0]))
    else $error("high result write lost");
endmodule

// File: tb/adcrf_result_format_tb.sv
// Testbench of the result formatting block: formats, busy bit, temperature channel, reset hold.
// Assumes the bench acts as the bus master and as the analog core answering each request.
module adcrf_result_format_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                          clk_sys = 1'b0;
  logic                          reset   = 1'b1;
  logic                          hsel    = 1'b0;
  logic [31:0]                   haddr   = 32'h0;
  logic [1:0]                    htrans  = 2'b00;
  logic                          hwrite  = 1'b0;
  logic [2:0]                    hsize   = 3'h2;
  logic [31:0]                   hwdata  = 32'h0;
  logic [31:0]                   hrdata;
  logic                          hreadyout;
  logic                          hresp;
  adcrf_pkg::adcrf_conv_req_type convReq;
  logic                          tempSelect;
  logic                          converterEnable;
  adcrf_pkg::adcrf_conv_rsp_type convRsp = '0;
  logic [31:0]                   rd;
  logic [7:0]                    lastHi;
  logic [7:0]                    lastLo;
  logic                          lastValid = 1'b0;
  int                            err_count = 0;
  int                            check_count = 0;
  // Acquisition wait that software leaves between a channel change and a start
  localparam int                 ACQ_CYCLES = 20;

  always #5 clk_sys = ~clk_sys;

  adcrf_result_format i_dut (.clk_sys(clk_sys), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .convReq(convReq), .tempSelect(tempSelect),
    .converterEnable(converterEnable), .convRsp(convRsp));

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_sys);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic conv_scn(input logic right, input logic [9:0] code, input logic [4:0] chan);
    logic [7:0] hi;
    logic [7:0] lo;
    hi = right ? {6'h00, code[9:8]} : code[9:2];
    lo = right ? code[7:0] : {code[1:0], 6'h00};
    bus(1'b1, adcrf_pkg::FORMAT_OFFSET, {24'h0, right, 7'h00});
    bus(1'b1, adcrf_pkg::CTRL_OFFSET, {24'h0, 1'b0, chan, 2'b01});
    repeat (ACQ_CYCLES) @(posedge clk_sys);
    bus(1'b1, adcrf_pkg::CTRL_OFFSET, {24'h0, 1'b0, chan, 2'b11});
    bus(1'b0, adcrf_pkg::CTRL_OFFSET, 32'h0);
    chk("busy", {24'h0, 1'b0, chan, 2'b11}, rd);
    chk("request", {26'h0, 1'b1, chan}, {26'h0, convReq.request, convReq.channel});
    chk("tempSelect", {31'h0, chan == 5'h1d}, {31'h0, tempSelect});
    bus(1'b0, adcrf_pkg::RESULT_HIGH_OFFSET, 32'h0);
    if (lastValid) chk("high before done", {24'h0, lastHi}, rd);
    @(posedge clk_sys);
    convRsp <= {1'b1, code};
    @(posedge clk_sys);
    convRsp <= {1'b0, ~code};
    bus(1'b0, adcrf_pkg::CTRL_OFFSET, 32'h0);
    chk("done", {24'h0, 1'b0, chan, 2'b01}, rd);
    bus(1'b0, adcrf_pkg::RESULT_HIGH_OFFSET, 32'h0);
    chk("high", {24'h0, hi}, rd);
    bus(1'b0, adcrf_pkg::RESULT_LOW_OFFSET, 32'h0);
    chk("low", {24'h0, lo}, rd);
    lastHi = hi;
    lastLo = lo;
    lastValid = 1'b1;
  endtask

  task automatic misc_scn();
    bus(1'b1, adcrf_pkg::CTRL_OFFSET, 32'h0000_0002);
    bus(1'b0, adcrf_pkg::CTRL_OFFSET, 32'h0);
    chk("start without enable", 32'h0, rd);
    bus(1'b1, adcrf_pkg::RESULT_HIGH_OFFSET, 32'h0000_005a);
    bus(1'b1, adcrf_pkg::RESULT_LOW_OFFSET, 32'h0000_00a5);
    bus(1'b0, adcrf_pkg::RESULT_HIGH_OFFSET, 32'h0);
    chk("high written", 32'h0000_005a, rd);
    bus(1'b0, adcrf_pkg::RESULT_LOW_OFFSET, 32'h0);
    chk("low written", 32'h0000_00a5, rd);
    lastHi = 8'h5a;
    lastLo = 8'ha5;
  endtask

  task automatic reset_scn();
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    bus(1'b0, adcrf_pkg::CTRL_OFFSET, 32'h0);
    chk("ctrl after reset", 32'h0, rd);
    bus(1'b0, adcrf_pkg::RESULT_HIGH_OFFSET, 32'h0);
    chk("high kept", {24'h0, lastHi}, rd);
    bus(1'b0, adcrf_pkg::RESULT_LOW_OFFSET, 32'h0);
    chk("low kept", {24'h0, lastLo}, rd);
    bus(1'b1, 8'h10, 32'hffffffff);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
  endtask

  task automatic results();
    if (err_count == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    conv_scn(1'b0, 10'h2d7, 5'h1d);
    conv_scn(1'b1, 10'h3ff, 5'h03);
    conv_scn(1'b1, 10'h155, 5'h1c);
    conv_scn(1'b0, 10'h000, 5'h1d);
    misc_scn();
    reset_scn();
    results();
  end

  initial begin
    #100us;
    err_count++;
    results();
  end
endmodule
